// *** dip_pkg.sv ***
// Purpose: Shared constants and types of the dual issue control block
// Assumes: Decode hands over a coarse operation kind per instruction
// Notes: Pairing matrix is indexed [older group * 6 + younger group]
package dip_pkg;

	localparam int NUM_SLOTS = 2;
	localparam int NUM_STAGES = 7;
	localparam int NUM_GROUPS = 6;
	localparam int REG_COUNT = 16;
	localparam int PAGE_LSB = 10;
	localparam logic [31:0] HALFWORD_STEP = 32'h0000_0002;

	typedef enum logic [3:0]
	{
		KIND_ALU = 4'h0,
		KIND_BRANCH = 4'h1,
		KIND_LOAD_STORE = 4'h2,
		KIND_FP_REG_MOVE = 4'h3,
		KIND_FP_COMM_XFER = 4'h4,
		KIND_FP_MEM = 4'h5,
		KIND_FP_SYS_XFER = 4'h6,
		KIND_FP_ARITH = 4'h7,
		KIND_FP_DIV_SQRT = 4'h8,
		KIND_MUL_ACC_WORD = 4'h9,
		KIND_MUL_ACC_LONG = 4'hA,
		KIND_HALF_MUL = 4'hB
	} dip_kind_e;

	typedef enum logic [2:0]
	{
		GRP_INTEGER_EXEC = 3'h0,
		GRP_BRANCH = 3'h1,
		GRP_LOAD_STORE = 3'h2,
		GRP_FPU_REG_MOVE = 3'h3,
		GRP_FPU_MEM_MOVE = 3'h4,
		GRP_FLOAT_EXEC = 3'h5
	} dip_group_e;

	typedef enum logic [0:0]
	{
		ST_RUN = 1'b0,
		ST_MAC_SECOND = 1'b1
	} dip_state_e;

	// Bit (older*6 + younger): 1 = the pair may go out together
	// Distinct groups pair except the two memory groups, which never share a cycle; two float exec ops pair too
	localparam logic [35:0] PAIR_ALLOWED = 36'hF_EBDE_BF7E;
	// Pairs issued together but serialised inside the floating-point unit
	localparam logic [35:0] PAIR_FPU_STALL = 36'h8_0000_0000;

	localparam logic [2:0] LAT_ALU = 3'h1;
	localparam logic [2:0] LAT_LOAD = 3'h2;
	localparam logic [2:0] LAT_MUL = 3'h3;
	localparam logic [2:0] LAT_FPU = 3'h4;
	localparam logic [2:0] DIV_OCCUPY_CYCLES = 3'h3;
	localparam logic [1:0] MAC_ISSUE_CYCLES = 2'h2;

endpackage

// *** dip_pair_if.sv ***
// Purpose: Carries group codes and pairing verdicts between the two modules
// Assumes: Purely combinational signals on the issue clock
// Notes: The pairing module owns every verdict
`timescale 1ns/1ps
interface dip_pair_if;
	dip_pkg::dip_kind_e kind_old;
	dip_pkg::dip_kind_e kind_new;
	dip_pkg::dip_group_e group_old;
	dip_pkg::dip_group_e group_new;
	logic pair_allowed;
	logic pair_fpu_stall;

	modport issue
	(
		output kind_old,
		output kind_new,
		input group_old,
		input group_new,
		input pair_allowed,
		input pair_fpu_stall
	);
	modport pairing
	(
		input kind_old,
		input kind_new,
		output group_old,
		output group_new,
		output pair_allowed,
		output pair_fpu_stall
	);
endinterface

// *** dip_group_pair.sv ***
// Purpose: Sorts operation kinds into issue groups and looks up pair matrix
// Assumes: Kinds come from decode of the two candidate instructions
// Notes: Combinational only
`timescale 1ns/1ps
module dip_group_pair
(
	dip_pair_if.pairing pif
);

	function automatic dip_pkg::dip_group_e group_of(input dip_pkg::dip_kind_e k);
		dip_pkg::dip_group_e g;
		g = dip_pkg::GRP_INTEGER_EXEC;
		unique case (k)
			dip_pkg::KIND_BRANCH: g = dip_pkg::GRP_BRANCH;
			dip_pkg::KIND_FP_REG_MOVE,
			dip_pkg::KIND_FP_COMM_XFER: g = dip_pkg::GRP_FPU_REG_MOVE;
			dip_pkg::KIND_FP_MEM,
			dip_pkg::KIND_FP_SYS_XFER: g = dip_pkg::GRP_FPU_MEM_MOVE;
			dip_pkg::KIND_LOAD_STORE,
			dip_pkg::KIND_MUL_ACC_WORD,
			dip_pkg::KIND_MUL_ACC_LONG: g = dip_pkg::GRP_LOAD_STORE;
			dip_pkg::KIND_FP_ARITH,
			dip_pkg::KIND_FP_DIV_SQRT: g = dip_pkg::GRP_FLOAT_EXEC;
			default: g = dip_pkg::GRP_INTEGER_EXEC;
		endcase
		return g;
	endfunction

	logic [5:0] index;

	assign pif.group_old = group_of(pif.kind_old);
	assign pif.group_new = group_of(pif.kind_new);
	assign index = 6'(pif.group_old) * 6'd6 + 6'(pif.group_new);
	// Matrix lookup also admits integer then branch
	assign pif.pair_allowed = dip_pkg::PAIR_ALLOWED[index];
	assign pif.pair_fpu_stall = dip_pkg::PAIR_FPU_STALL[index];

endmodule

// *** dip_issue_ctrl.sv ***
// Purpose: Dual issue control of a seven stage two-way pipeline
// Assumes: Slot 0 holds the older instruction, slot 1 the one after it
// Notes: Fetch removes o_take_count entries from its queue each cycle
`timescale 1ns/1ps
module dip_issue_ctrl
#(
	parameter int REGS = dip_pkg::REG_COUNT
)
(
	input wire logic i_sys_clk,
	input wire logic i_srst,
	input wire logic [1:0] i_ins_valid,
	input wire logic [1:0][3:0] i_ins_kind,
	input wire logic [1:0][31:0] i_ins_addr,
	input wire logic [1:0][3:0] i_ins_src_a,
	input wire logic [1:0][3:0] i_ins_src_b,
	input wire logic [1:0][3:0] i_ins_dst,
	input wire logic [1:0] i_ins_dst_en,
	output logic [1:0] o_take_count,
	output logic [1:0] o_issue_valid,
	output logic [1:0][3:0] o_issue_kind,
	output logic o_fpu_hold_second,
	output logic o_mac_second_pass,
	output logic o_divider_busy,
	output logic o_mult_store,
	output logic [4:0] o_stage_busy
);

	dip_pair_if pif ();

	dip_group_pair u_group_pair
	(
		.pif(pif.pairing)
	);

	dip_pkg::dip_state_e state_reg;
	dip_pkg::dip_kind_e kind0;
	dip_pkg::dip_kind_e kind1;
	logic [2:0] sb_cnt_reg [REGS];
	logic [2:0] div_cnt_reg;
	logic [2:0] lat0;
	logic [2:0] lat1;
	logic [1:0] mul_pipe_reg;
	logic [4:0] stage_reg;
	logic hazard0;
	logic hazard1;
	logic intra_dep;
	logic same_page;
	logic adjacent;
	logic div_block0;
	logic div_block1;
	logic is_mac0;
	logic is_mac1;
	logic can0;
	logic pair_ok;
	logic take0;
	logic take1;

	assign kind0 = dip_pkg::dip_kind_e'(i_ins_kind[0]);
	assign kind1 = dip_pkg::dip_kind_e'(i_ins_kind[1]);
	assign pif.kind_old = kind0;
	assign pif.kind_new = kind1;

	function automatic logic [2:0] latency_of(input dip_pkg::dip_kind_e k);
		logic [2:0] l;
		l = dip_pkg::LAT_ALU;
		unique case (k)
			dip_pkg::KIND_LOAD_STORE,
			dip_pkg::KIND_FP_MEM: l = dip_pkg::LAT_LOAD;
			dip_pkg::KIND_HALF_MUL,
			dip_pkg::KIND_MUL_ACC_WORD,
			dip_pkg::KIND_MUL_ACC_LONG: l = dip_pkg::LAT_MUL;
			dip_pkg::KIND_FP_ARITH,
			dip_pkg::KIND_FP_DIV_SQRT: l = dip_pkg::LAT_FPU;
			default: l = dip_pkg::LAT_ALU;
		endcase
		return l;
	endfunction

	assign lat0 = latency_of(kind0);
	assign lat1 = latency_of(kind1);

	// Pending results block any source or destination that names them
	assign hazard0 = sb_cnt_reg[i_ins_src_a[0]] != 3'h0
		|| sb_cnt_reg[i_ins_src_b[0]] != 3'h0
		|| (i_ins_dst_en[0] && sb_cnt_reg[i_ins_dst[0]] != 3'h0);
	assign hazard1 = sb_cnt_reg[i_ins_src_a[1]] != 3'h0
		|| sb_cnt_reg[i_ins_src_b[1]] != 3'h0
		|| (i_ins_dst_en[1] && sb_cnt_reg[i_ins_dst[1]] != 3'h0);
	// The older one is in flight once paired, so its result counts too
	assign intra_dep = i_ins_dst_en[0]
		&& (i_ins_dst[0] == i_ins_src_a[1] || i_ins_dst[0] == i_ins_src_b[1]
		|| (i_ins_dst_en[1] && i_ins_dst[0] == i_ins_dst[1]));

	assign same_page = i_ins_addr[0][31:dip_pkg::PAGE_LSB]
		== i_ins_addr[1][31:dip_pkg::PAGE_LSB];
	assign adjacent = i_ins_addr[1]
		== i_ins_addr[0] + dip_pkg::HALFWORD_STEP;

	assign div_block0 = kind0 == dip_pkg::KIND_FP_DIV_SQRT
		&& div_cnt_reg != 3'h0;
	assign div_block1 = kind1 == dip_pkg::KIND_FP_DIV_SQRT
		&& (div_cnt_reg != 3'h0 || kind0 == dip_pkg::KIND_FP_DIV_SQRT);
	assign is_mac0 = kind0 == dip_pkg::KIND_MUL_ACC_WORD
		|| kind0 == dip_pkg::KIND_MUL_ACC_LONG;
	assign is_mac1 = kind1 == dip_pkg::KIND_MUL_ACC_WORD
		|| kind1 == dip_pkg::KIND_MUL_ACC_LONG;

	// Stalled until operands are ready; no issue in a second MAC pass
	assign can0 = i_ins_valid[0] && !hazard0 && !div_block0
		&& state_reg == dip_pkg::ST_RUN;

	// Two-issue-cycle operations never pair, keeping their pass slot free
	assign pair_ok = can0 && i_ins_valid[1]
		&& same_page && adjacent
		&& pif.pair_allowed
		&& !hazard1 && !intra_dep
		&& !div_block1 && !is_mac0 && !is_mac1;

	assign take0 = can0;
	assign take1 = pair_ok;
	// A refused younger instruction simply stays at the head of fetch
	assign o_take_count = {take1, take0 && !take1};

	always_ff @(posedge i_sys_clk)
	begin
		if (i_srst)
			state_reg <= dip_pkg::ST_RUN;
		else
		begin
			unique case (state_reg)
				dip_pkg::ST_RUN:
					if (take0 && is_mac0)
						state_reg <= dip_pkg::ST_MAC_SECOND;
				dip_pkg::ST_MAC_SECOND:
					state_reg <= dip_pkg::ST_RUN;
			endcase
		end
	end

	always_ff @(posedge i_sys_clk)
	begin
		if (i_srst)
		begin
			o_issue_valid <= 2'h0;
			o_issue_kind <= '0;
			o_fpu_hold_second <= 1'b0;
		end
		else
		begin
			o_issue_valid <= {take1, take0};
			o_issue_kind <= i_ins_kind;
			// FPU holds the younger back a cycle inside its own pipe
			o_fpu_hold_second <= take1 && pif.pair_fpu_stall;
		end
	end

	always_ff @(posedge i_sys_clk)
	begin
		if (i_srst)
			o_mac_second_pass <= 1'b0;
		else
			o_mac_second_pass <= state_reg == dip_pkg::ST_RUN
				&& take0 && is_mac0;
	end

	// Decode, three execute stages and write-back; fetch lives upstream
	always_ff @(posedge i_sys_clk)
	begin
		if (i_srst)
			stage_reg <= 5'h00;
		else
			stage_reg <= {stage_reg[3:0], take0 || state_reg
				== dip_pkg::ST_MAC_SECOND};
	end
	assign o_stage_busy = stage_reg;

	// Half multiplies go decode, E1, then store the result during M2
	always_ff @(posedge i_sys_clk)
	begin
		if (i_srst)
		begin
			mul_pipe_reg <= 2'h0;
			o_mult_store <= 1'b0;
		end
		else
		begin
			mul_pipe_reg <= {mul_pipe_reg[0],
				(take0 && kind0 == dip_pkg::KIND_HALF_MUL)
				|| (take1 && kind1 == dip_pkg::KIND_HALF_MUL)};
			o_mult_store <= mul_pipe_reg[1];
		end
	end

	always_ff @(posedge i_sys_clk)
	begin
		if (i_srst)
			div_cnt_reg <= 3'h0;
		else if ((take0 && kind0 == dip_pkg::KIND_FP_DIV_SQRT)
			|| (take1 && kind1 == dip_pkg::KIND_FP_DIV_SQRT))
			div_cnt_reg <= dip_pkg::DIV_OCCUPY_CYCLES;
		else if (div_cnt_reg != 3'h0)
			div_cnt_reg <= div_cnt_reg - 3'h1;
	end
	assign o_divider_busy = div_cnt_reg != 3'h0;

	for (genvar r = 0; r < REGS; r++)
	begin : g_sb
		always_ff @(posedge i_sys_clk)
		begin
			if (i_srst)
				sb_cnt_reg[r] <= 3'h0;
			else if (take1 && i_ins_dst_en[1] && i_ins_dst[1] == 4'(r))
				sb_cnt_reg[r] <= lat1;
			else if (take0 && i_ins_dst_en[0] && i_ins_dst[0] == 4'(r))
				sb_cnt_reg[r] <= lat0;
			else if (sb_cnt_reg[r] != 3'h0)
				sb_cnt_reg[r] <= sb_cnt_reg[r] - 3'h1;
		end
	end

	default clocking cb @(posedge i_sys_clk);
	endclocking
	default disable iff (i_srst);

	// Checks watch the issue verdicts and the outputs they lead to
	a_pair_both_valid: assert property
		(take1 |-> i_ins_valid == 2'b11)
		else $error("pair issued with an invalid slot");

	a_pair_same_page: assert property
		(take1 |-> same_page && adjacent)
		else $error("pair crosses a page or is not adjacent");

	a_pair_matrix: assert property
		(take1 |-> pif.pair_allowed)
		else $error("pair issued against the group matrix");

	a_older_no_hazard: assert property
		(take0 |-> !hazard0)
		else $error("older issued with a pending operand");

	a_younger_no_hazard: assert property
		(take1 |-> !hazard1 && !intra_dep)
		else $error("younger issued with an operand conflict");

	a_dual_registered: assert property
		(take1 |=> o_issue_valid == 2'b11)
		else $error("dual issue not reflected on outputs");

	a_mac_two_cycles: assert property
		(take0 && is_mac0 |=> o_take_count == 2'h0
		##1 state_reg == dip_pkg::ST_RUN)
		else $error("multiply-accumulate did not hold two issue cycles");

	a_div_exclusive: assert property
		($rose(o_divider_busy)
		|-> !(take0 && kind0 == dip_pkg::KIND_FP_DIV_SQRT)[*3])
		else $error("divider reused while occupied");

	a_stage_flow: assert property
		(stage_reg[0] |-> ##4 o_stage_busy[4])
		else $error("issued slot did not reach write-back");

	a_half_mul_store: assert property
		(take0 && kind0 == dip_pkg::KIND_HALF_MUL |-> ##3 o_mult_store)
		else $error("half multiply missed result store");

	a_ex_branch_pair: assert property
		(pif.group_old == dip_pkg::GRP_INTEGER_EXEC
		&& pif.group_new == dip_pkg::GRP_BRANCH |-> pif.pair_allowed)
		else $error("integer then branch refused by matrix");

	a_held_in_order: assert property
		(take0 && !take1 && i_ins_valid[1] |-> o_take_count == 2'h1)
		else $error("younger not held behind older");

	a_younger_needs_older: assert property
		(take1 |-> take0)
		else $error("younger issued without the older");

	a_older_valid: assert property
		(take0 |-> i_ins_valid[0])
		else $error("invalid older slot issued");

	a_single_alone: assert property
		(take0 && !i_ins_valid[1] |-> !take1)
		else $error("invalid younger slot paired");

	a_hazard_stall: assert property
		(i_ins_valid[0] && hazard0 |-> o_take_count == 2'h0)
		else $error("issue went on past a pending operand");

	a_mac_alone: assert property
		(take0 && is_mac0 |-> !take1)
		else $error("multiply-accumulate paired");

	a_mac_pass_pulse: assert property
		(take0 && is_mac0 |=> o_mac_second_pass)
		else $error("second multiply-accumulate pass not flagged");

	a_mac_issue_rate: assert property
		(state_reg == dip_pkg::ST_MAC_SECOND |-> o_take_count == 2'h0)
		else $error("issue during the second multiply-accumulate pass");

	a_div_refused: assert property
		(o_divider_busy && kind0 == dip_pkg::KIND_FP_DIV_SQRT |-> !take0)
		else $error("divide issued into a busy divider");

	a_div_busy_span: assert property
		(take0 && kind0 == dip_pkg::KIND_FP_DIV_SQRT |=> o_divider_busy[*3])
		else $error("divider occupancy too short");

	a_fpu_hold: assert property
		(take1 && pif.pair_fpu_stall |=> o_fpu_hold_second)
		else $error("marked pair not held in the FPU");

	a_issue_kind: assert property
		(take0 |=> o_issue_kind[0] == $past(i_ins_kind[0]))
		else $error("issued kind does not follow the older slot");

	c_dual_issue: cover property (take1);
	c_younger_held: cover property (take0 && !take1 && i_ins_valid[1]);
	c_mac_issue: cover property (take0 && is_mac0);
	c_div_stall: cover property (i_ins_valid[0] && div_block0);
	c_fpu_marked: cover property (take1 && pif.pair_fpu_stall);

endmodule

// *** dip_fetch_model.sv ***
// Purpose: Fetch side model feeding the dual issue control
// Assumes: Bench loads a short program, then calls go
// Notes: Idle slots carry a pattern that changes every cycle
`timescale 1ns/1ps
module dip_fetch_model
(
	input wire logic i_clk,
	input wire logic i_srst,
	input wire logic [1:0] i_take,
	output logic [1:0] o_valid,
	output logic [1:0][3:0] o_kind,
	output logic [1:0][31:0] o_addr,
	output logic [1:0][3:0] o_src_a,
	output logic [1:0][3:0] o_src_b,
	output logic [1:0][3:0] o_dst,
	output logic [1:0] o_dst_en
);
	logic [16:0] mem[16];
	logic [31:0] adr[16];
	logic [1:0] tk[$];
	int len = 0;
	int ptr = 0;
	logic [3:0] cnt = 4'h0;

	task put(input int i, input logic [16:0] w, input logic [31:0] a);
		mem[i] = w;
		adr[i] = a;
	endtask

	task go(input int n);
		tk.delete();
		ptr = 0;
		len = n;
	endtask

	// Refused slots stay in place, so they are offered again
	always @(negedge i_clk)
	begin
		cnt <= cnt + 4'h1;
		for (int s = 0; s < 2; s++)
		begin
			o_valid[s] <= ptr + s < len;
			{o_dst_en[s], o_dst[s], o_src_b[s], o_src_a[s], o_kind[s]} <=
				(ptr + s < len) ? mem[ptr + s] : {1'b0, {4{cnt}}};
			o_addr[s] <= (ptr + s < len) ? adr[ptr + s] : {8{cnt}};
		end
	end

	// Take count is not valid under reset, so it is ignored there
	always @(posedge i_clk)
		if (!i_srst && ptr < len)
		begin
			tk.push_back(i_take);
			ptr = ptr + int'(i_take);
		end
endmodule

// *** dip_tb.sv ***
// Purpose: Self-checking bench of the dual issue control
// Assumes: Fetch model offers slots at the falling edge
// Notes: Each scenario runs a short program and judges the issue trace
`timescale 1ns/1ps
module tb;
	logic i_sys_clk = 1'b0;
	logic i_srst = 1'b1;
	logic [1:0] f_valid, f_den, take, iss_valid;
	logic [1:0][3:0] f_kind, f_sa, f_sb, f_dst, iss_kind;
	logic [1:0][31:0] f_addr;
	logic fpu_hold, mac2, div_busy, mul_st;
	logic [4:0] stage;
	int failures = 0;
	int samples_checked = 0;

	dip_issue_ctrl uut
	(
		.i_sys_clk(i_sys_clk), .i_srst(i_srst), .i_ins_valid(f_valid),
		.i_ins_kind(f_kind), .i_ins_addr(f_addr), .i_ins_src_a(f_sa),
		.i_ins_src_b(f_sb), .i_ins_dst(f_dst), .i_ins_dst_en(f_den),
		.o_take_count(take), .o_issue_valid(iss_valid),
		.o_issue_kind(iss_kind), .o_fpu_hold_second(fpu_hold),
		.o_mac_second_pass(mac2), .o_divider_busy(div_busy),
		.o_mult_store(mul_st), .o_stage_busy(stage)
	);

	dip_fetch_model fe
	(
		.i_clk(i_sys_clk), .i_srst(i_srst), .i_take(take),
		.o_valid(f_valid), .o_kind(f_kind), .o_addr(f_addr),
		.o_src_a(f_sa), .o_src_b(f_sb), .o_dst(f_dst), .o_dst_en(f_den)
	);

	initial
		forever #2 i_sys_clk = ~i_sys_clk;

	task finish_test;
		if (failures == 0 && samples_checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task check(input string nm, input logic [31:0] seen,
		input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			failures++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task cyc;
		@(posedge i_sys_clk);
		#1;
	endtask

	// Second source is fixed, so hazards come only from the first
	function automatic logic [16:0] ins(input logic [3:0] k,
		input logic [3:0] s, input logic [3:0] d, input logic e);
		return {e, d, 4'hE, s, k};
	endfunction

	// Extra cycles let the scoreboard and divider settle between programs
	task drain;
		for (int i = 0; i < 40 && fe.ptr < fe.len; i++)
			cyc;
		if (fe.ptr < fe.len)
		begin
			failures++;
			finish_test;
		end
		else
			repeat (8) cyc;
	endtask

	// Expected take counts, one hex digit per cycle, oldest first
	task takes(input string nm, input int n, input logic [23:0] e);
		check(nm, fe.tk.size(), n);
		for (int i = 0; i < n; i++)
			check(nm, fe.tk[i], e[4 * (n - 1 - i) +: 4]);
	endtask

	task t_pair_branch;
		fe.put(0, ins(4'h0, 4'h2, 4'h1, 1'b1), 32'h0000_0100);
		fe.put(1, ins(4'h1, 4'h3, 4'h0, 1'b0), 32'h0000_0102);
		fe.go(2);
		cyc;
		check("take", fe.tk[0], 2);
		check("issue valid", iss_valid, 2'b11);
		check("issue kind", iss_kind, 8'h10);
		check("decode busy", stage[0], 1);
		repeat (3) cyc;
		check("wb early", stage[4], 0);
		cyc;
		check("wb busy", stage[4], 1);
		drain;
	endtask

	task t_matrix;
		int g[8] = '{0, 1, 2, 3, 3, 4, 4, 5};
		int x;
		logic e;
		logic h;
		for (int i = 0; i < 8; i++)
			for (int j = 0; j < 8; j++)
			begin
				x = g[i] * 6 + g[j];
				e = dip_pkg::PAIR_ALLOWED[x];
				h = e & dip_pkg::PAIR_FPU_STALL[x];
				fe.put(0, ins(i[3:0], 4'h2, 4'h0, 1'b0), 32'h0000_0200);
				fe.put(1, ins(j[3:0], 4'h3, 4'h0, 1'b0), 32'h0000_0202);
				fe.go(2);
				cyc;
				check("pair take", fe.tk[0], e ? 2 : 1);
				check("pair kind", iss_kind[0], i);
				check("fpu hold", fpu_hold, h);
				drain;
			end
	endtask

	task t_page;
		logic [31:0] a[3] = '{32'h0000_03FE, 32'h0000_03FC, 32'h0000_0200};
		logic [31:0] b[3] = '{32'h0000_0400, 32'h0000_03FE, 32'h0000_0204};
		for (int i = 0; i < 3; i++)
		begin
			fe.put(0, ins(4'h0, 4'h2, 4'h0, 1'b0), a[i]);
			fe.put(1, ins(4'h1, 4'h3, 4'h0, 1'b0), b[i]);
			fe.go(2);
			drain;
			takes("page", i == 1 ? 1 : 2, i == 1 ? 24'h2 : 24'h11);
		end
	endtask

	task t_dep;
		fe.put(0, ins(4'hB, 4'h2, 4'h7, 1'b1), 32'h0000_0300);
		fe.put(1, ins(4'h1, 4'h3, 4'h0, 1'b0), 32'h0000_0302);
		fe.put(2, ins(4'h0, 4'h2, 4'h0, 1'b0), 32'h0000_0304);
		fe.put(3, ins(4'h1, 4'h7, 4'h0, 1'b0), 32'h0000_0306);
		fe.go(4);
		repeat (2) cyc;
		check("alone", iss_valid, 2'b01);
		check("alone kind", iss_kind[0], 0);
		check("store early", mul_st, 0);
		cyc;
		check("store", mul_st, 1);
		cyc;
		check("late kind", iss_kind[0], 1);
		check("held", iss_valid, 2'b00);
		drain;
		// A multiply result blocks its readers for three cycles
		takes("dep", 5, 24'h21001);
		// Younger branch reads the older's result through its second source
		fe.put(1, {1'b0, 4'h0, 4'h7, 4'h3, 4'h1}, 32'h0000_0302);
		fe.go(2);
		drain;
		takes("stall", 5, 24'h10001);
	endtask

	task t_single;
		fe.put(0, ins(4'h0, 4'h2, 4'h0, 1'b0), 32'h0000_0100);
		fe.go(1);
		cyc;
		check("single", iss_valid, 2'b01);
		drain;
		takes("single", 1, 24'h1);
	endtask

	task t_mac;
		for (int k = 9; k < 11; k++)
		begin
			fe.put(0, ins(k[3:0], 4'h2, 4'h0, 1'b0), 32'h0000_0100);
			fe.put(1, ins(4'h0, 4'h3, 4'h0, 1'b0), 32'h0000_0102);
			fe.go(2);
			cyc;
			check("mac pass", mac2, 1);
			cyc;
			check("mac done", mac2, 0);
			drain;
			takes("mac", 3, 24'h101);
		end
	endtask

	task t_div;
		fe.put(0, ins(4'h8, 4'h2, 4'h0, 1'b0), 32'h0000_0100);
		fe.put(1, ins(4'h8, 4'h3, 4'h0, 1'b0), 32'h0000_0102);
		fe.go(2);
		cyc;
		check("div busy", div_busy, 1);
		repeat (2) cyc;
		check("div busy end", div_busy, 1);
		drain;
		takes("div", 5, 24'h10001);
	endtask

	initial
	begin
		repeat (3) @(negedge i_sys_clk);
		i_srst = 1'b0;
		cyc;
		t_pair_branch;
		t_matrix;
		t_page;
		t_dep;
		t_single;
		t_mac;
		t_div;
		finish_test;
	end
endmodule
